// file: core/bcf_extract.sv
// registered field extraction for branch and condition-register instructions
// How it works
// - lowercase split fields join pieces left to right
// - uppercase split fields join in selectable order
// - bits 11-20 give the special-register selector
// - bits 11-20 give the time-base half selector
// - flag clear: target is offset plus address
// - flag set: target is sign-extended offset only
// - bits 16-29 append 00, sign-extend to 32
// - bits 11-15 pick tested condition bit
// - bits 6-10 are the branch options field
// - bits 11-15 and 16-20 are source bits
// - bits 6-10 pick destination bit
// - bits 6-8 pick destination field
// - bits 11-13 pick source field
// - bits 0-5 are always the primary opcode
// - low two address bits ignored, targets aligned
// - nonzero reserved or wrong fixed field: invalid
`timescale 1ns/1ps

module bcf_extract (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // instruction from fetch
    input wire logic in_valid,
    input wire logic [31:0] instr_word,
    input wire logic [31:0] current_instr_address,
    // per-instruction hints from the opcode decoder
    input wire logic long_branch_form,
    input wire bcf_pkg::bcf_join_t split_order,
    input wire logic [31:0] reserved_mask,
    input wire logic [31:0] fixed_mask,
    input wire logic [31:0] fixed_value,
    // decoded fields
    output logic out_valid,
    output logic [5:0] primary_opcode,
    output logic [9:0] spr_selector,
    output logic [9:0] timebase_selector,
    output logic timebase_low_word,
    output logic timebase_high_word,
    output logic absolute_address_flag,
    output logic [31:0] branch_displacement,
    output logic [31:0] long_branch_offset,
    output logic [31:0] branch_target,
    output logic [4:0] branch_condition_selector,
    output logic [4:0] branch_options_field,
    output logic [4:0] cond_src_bit_a,
    output logic [4:0] cond_src_bit_b,
    output logic [4:0] cond_dest_bit,
    output logic [2:0] cond_dest_field,
    output logic [2:0] cond_src_field,
    output logic [5:0] rotate_count,
    output logic [5:0] mask_begin,
    output logic [5:0] mask_end,
    output logic invalid_form
);
    import bcf_pkg::*;

    // big-endian field pick, right-aligned in the result
    function automatic logic [31:0] fld(
        input logic [31:0] word,
        input int first,
        input int last
    );
        logic [31:0] ones;
        ones = 32'hffff_ffff >> (31 - (last - first));
        fld = (word >> (31 - last)) & ones;
    endfunction : fld

    // one big-endian bit
    function automatic logic bit_at(
        input logic [31:0] word,
        input int pos
    );
        bit_at = word[31 - pos];
    endfunction : bit_at

    // join a five-bit piece with a second piece
    function automatic logic [9:0] join_ten(
        input logic [4:0] first_piece,
        input logic [4:0] second_piece,
        input bcf_join_t order
    );
        if (order == BCF_JOIN_SWAP) begin
            join_ten = {second_piece, first_piece};
        end else begin
            join_ten = {first_piece, second_piece};
        end
    endfunction : join_ten

    // six-bit uppercase field from five bits plus one
    function automatic logic [5:0] join_six(
        input logic [4:0] body,
        input logic ext,
        input bcf_join_t order
    );
        if (order == BCF_JOIN_SWAP) begin
            join_six = {ext, body};
        end else begin
            join_six = {body, ext};
        end
    endfunction : join_six

    // next values
    logic next_out_valid;
    logic [5:0] next_primary_opcode;
    logic [9:0] next_spr_selector;
    logic [9:0] next_timebase_selector;
    logic next_timebase_low_word;
    logic next_timebase_high_word;
    logic next_absolute_address_flag;
    logic [31:0] next_branch_displacement;
    logic [31:0] next_long_branch_offset;
    logic [31:0] next_branch_target;
    logic [4:0] next_branch_condition_selector;
    logic [4:0] next_branch_options_field;
    logic [4:0] next_cond_src_bit_a;
    logic [4:0] next_cond_src_bit_b;
    logic [4:0] next_cond_dest_bit;
    logic [2:0] next_cond_dest_field;
    logic [2:0] next_cond_src_field;
    logic [5:0] next_rotate_count;
    logic [5:0] next_mask_begin;
    logic [5:0] next_mask_end;
    logic next_invalid_form;

    // shift in two zero bits, then copy the field's top bit upward
    function automatic logic [31:0] word_offset(
        input logic [31:0] raw_field,
        input int width
    );
        logic [31:0] upper;
        if (raw_field[width - 1]) begin
            upper = 32'hffff_ffff << (width + 2);
        end else begin
            upper = 32'h0000_0000;
        end
        word_offset = (raw_field << 2) | upper;
    endfunction : word_offset

    // raw pieces
    logic [4:0] sel_a;
    logic [4:0] sel_b;
    logic [13:0] disp_raw;
    logic [23:0] long_raw;
    logic [31:0] offset;
    logic [31:0] base_addr;
    logic [31:0] target_sum;
    logic [4:0] rot_body;
    logic rot_ext;
    logic [4:0] mbeg_body;
    logic mbeg_ext;
    logic [4:0] mend_body;
    logic mend_ext;
    logic reserved_hit;
    logic fixed_miss;

    // control, opcode and register selectors
    always_comb begin
        sel_a = 5'(fld(instr_word, BCF_SEL_A_FIRST, BCF_SEL_A_LAST));
        sel_b = 5'(fld(instr_word, BCF_SEL_B_FIRST, BCF_SEL_B_LAST));
        next_out_valid = in_valid;
        next_primary_opcode = 6'(fld(instr_word, BCF_OPC_FIRST, BCF_OPC_LAST));

        // both selectors share bits 11-20, joined left to right
        next_spr_selector = join_ten(sel_a, sel_b, BCF_JOIN_LTR);
        next_timebase_selector = join_ten(sel_a, sel_b, BCF_JOIN_LTR);
        // unknown codes select neither half
        if (next_timebase_selector == BCF_TB_LOW_CODE) begin
            next_timebase_low_word = 1'b1;
            next_timebase_high_word = 1'b0;
        end else if (next_timebase_selector == BCF_TB_HIGH_CODE) begin
            next_timebase_low_word = 1'b0;
            next_timebase_high_word = 1'b1;
        end else begin
            next_timebase_low_word = 1'b0;
            next_timebase_high_word = 1'b0;
        end
    end

    // branch offsets and target
    always_comb begin
        disp_raw = 14'(fld(instr_word, BCF_DISP_FIRST, BCF_DISP_LAST));
        long_raw = 24'(fld(instr_word, BCF_LONG_OFS_FIRST, BCF_LONG_OFS_LAST));
        // the stray low address bits must never reach the adder
        base_addr = current_instr_address & BCF_ALIGN_MASK;

        // displacements carry two zero bits, then sign-extend
        next_branch_displacement = word_offset(32'(disp_raw), $bits(disp_raw));
        next_long_branch_offset = word_offset(32'(long_raw), $bits(long_raw));

        next_absolute_address_flag = bit_at(instr_word, BCF_ABS_FLAG_BIT);
        if (long_branch_form) begin
            offset = next_long_branch_offset;
        end else begin
            offset = next_branch_displacement;
        end
        if (next_absolute_address_flag) begin
            target_sum = offset;
        end else begin
            // wraps modulo 2^32, as the address space does
            target_sum = 32'(base_addr + offset);
        end
        // generated addresses never carry the two low bits
        next_branch_target = target_sum & BCF_ALIGN_MASK;
    end

    // condition-register and branch control fields
    always_comb begin
        next_branch_condition_selector = 5'(fld(instr_word, BCF_COND_SEL_FIRST, BCF_COND_SEL_LAST));
        next_branch_options_field = 5'(fld(instr_word, BCF_OPTS_FIRST, BCF_OPTS_LAST));
        next_cond_src_bit_a = 5'(fld(instr_word, BCF_SRC_BIT_A_FIRST, BCF_SRC_BIT_A_LAST));
        next_cond_src_bit_b = 5'(fld(instr_word, BCF_SRC_BIT_B_FIRST, BCF_SRC_BIT_B_LAST));
        next_cond_dest_bit = 5'(fld(instr_word, BCF_DEST_BIT_FIRST, BCF_DEST_BIT_LAST));
        next_cond_dest_field = 3'(fld(instr_word, BCF_DEST_FLD_FIRST, BCF_DEST_FLD_LAST));
        next_cond_src_field = 3'(fld(instr_word, BCF_SRC_FLD_FIRST, BCF_SRC_FLD_LAST));
    end

    // uppercase split fields and form check
    always_comb begin
        rot_body = 5'(fld(instr_word, BCF_ROT_FIRST, BCF_ROT_LAST));
        rot_ext = bit_at(instr_word, BCF_ROT_EXT_BIT);
        mbeg_body = 5'(fld(instr_word, BCF_MBEG_FIRST, BCF_MBEG_LAST));
        mbeg_ext = bit_at(instr_word, BCF_MBEG_EXT_BIT);
        mend_body = 5'(fld(instr_word, BCF_MEND_FIRST, BCF_MEND_LAST));
        mend_ext = bit_at(instr_word, BCF_MEND_EXT_BIT);
        // order is per instruction, so the opcode decoder supplies it
        next_rotate_count = join_six(rot_body, rot_ext, split_order);
        next_mask_begin = join_six(mbeg_body, mbeg_ext, split_order);
        next_mask_end = join_six(mend_body, mend_ext, split_order);

        // masks come from the opcode decoder; this stage only checks them
        reserved_hit = |(instr_word & reserved_mask);
        fixed_miss = |((instr_word ^ fixed_value) & fixed_mask);
        next_invalid_form = reserved_hit | fixed_miss;
    end

    // registers: control and selectors
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            primary_opcode <= BCF_RST_SIX;
            spr_selector <= BCF_RST_SEL;
            timebase_selector <= BCF_RST_SEL;
            timebase_low_word <= 1'b0;
            timebase_high_word <= 1'b0;
        end else begin
            out_valid <= next_out_valid;
            primary_opcode <= next_primary_opcode;
            spr_selector <= next_spr_selector;
            timebase_selector <= next_timebase_selector;
            timebase_low_word <= next_timebase_low_word;
            timebase_high_word <= next_timebase_high_word;
        end
    end

    // registers: branch offsets and target
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            absolute_address_flag <= 1'b0;
            branch_displacement <= BCF_RST_WORD;
            long_branch_offset <= BCF_RST_WORD;
            branch_target <= BCF_RST_WORD;
        end else begin
            absolute_address_flag <= next_absolute_address_flag;
            branch_displacement <= next_branch_displacement;
            long_branch_offset <= next_long_branch_offset;
            branch_target <= next_branch_target;
        end
    end

    // registers: condition-register fields
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            branch_condition_selector <= BCF_RST_FIVE;
            branch_options_field <= BCF_RST_FIVE;
            cond_src_bit_a <= BCF_RST_FIVE;
            cond_src_bit_b <= BCF_RST_FIVE;
            cond_dest_bit <= BCF_RST_FIVE;
            cond_dest_field <= BCF_RST_THREE;
            cond_src_field <= BCF_RST_THREE;
        end else begin
            branch_condition_selector <= next_branch_condition_selector;
            branch_options_field <= next_branch_options_field;
            cond_src_bit_a <= next_cond_src_bit_a;
            cond_src_bit_b <= next_cond_src_bit_b;
            cond_dest_bit <= next_cond_dest_bit;
            cond_dest_field <= next_cond_dest_field;
            cond_src_field <= next_cond_src_field;
        end
    end

    // registers: split fields and form flag
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rotate_count <= BCF_RST_SIX;
            mask_begin <= BCF_RST_SIX;
            mask_end <= BCF_RST_SIX;
            invalid_form <= 1'b0;
        end else begin
            rotate_count <= next_rotate_count;
            mask_begin <= next_mask_begin;
            mask_end <= next_mask_end;
            invalid_form <= next_invalid_form;
        end
    end
endmodule : bcf_extract

// file: shared/bcf_pkg.sv
// field positions, reset values and join orders for the branch and condition-register field extractor
package bcf_pkg;
    // big-endian bit numbers: bit 0 is the msb of the word
    localparam int BCF_WORD_W = 32;
    localparam int BCF_OPC_FIRST = 0;
    localparam int BCF_OPC_LAST = 5;
    localparam int BCF_SEL_A_FIRST = 11;
    localparam int BCF_SEL_A_LAST = 15;
    localparam int BCF_SEL_B_FIRST = 16;
    localparam int BCF_SEL_B_LAST = 20;
    localparam int BCF_ABS_FLAG_BIT = 30;
    localparam int BCF_DISP_FIRST = 16;
    localparam int BCF_DISP_LAST = 29;
    localparam int BCF_LONG_OFS_FIRST = 6;
    localparam int BCF_LONG_OFS_LAST = 29;
    localparam int BCF_COND_SEL_FIRST = 11;
    localparam int BCF_COND_SEL_LAST = 15;
    localparam int BCF_OPTS_FIRST = 6;
    localparam int BCF_OPTS_LAST = 10;
    localparam int BCF_SRC_BIT_A_FIRST = 11;
    localparam int BCF_SRC_BIT_A_LAST = 15;
    localparam int BCF_SRC_BIT_B_FIRST = 16;
    localparam int BCF_SRC_BIT_B_LAST = 20;
    localparam int BCF_DEST_BIT_FIRST = 6;
    localparam int BCF_DEST_BIT_LAST = 10;
    localparam int BCF_DEST_FLD_FIRST = 6;
    localparam int BCF_DEST_FLD_LAST = 8;
    localparam int BCF_SRC_FLD_FIRST = 11;
    localparam int BCF_SRC_FLD_LAST = 13;
    localparam int BCF_ROT_FIRST = 16;
    localparam int BCF_ROT_LAST = 20;
    localparam int BCF_ROT_EXT_BIT = 30;
    localparam int BCF_MBEG_FIRST = 21;
    localparam int BCF_MBEG_LAST = 25;
    localparam int BCF_MBEG_EXT_BIT = 26;
    localparam int BCF_MEND_FIRST = 26;
    localparam int BCF_MEND_LAST = 30;
    localparam int BCF_MEND_EXT_BIT = 21;
    // address alignment: instructions are four bytes
    localparam logic [31:0] BCF_ALIGN_MASK = 32'hffff_fffc;
    // time base selector codes, plain defaults
    localparam logic [9:0] BCF_TB_LOW_CODE = 10'h001;
    localparam logic [9:0] BCF_TB_HIGH_CODE = 10'h002;
    // reset values
    localparam logic [31:0] BCF_RST_WORD = 32'h0000_0000;
    localparam logic [9:0] BCF_RST_SEL = 10'h000;
    localparam logic [5:0] BCF_RST_SIX = 6'h00;
    localparam logic [4:0] BCF_RST_FIVE = 5'h00;
    localparam logic [2:0] BCF_RST_THREE = 3'h0;

    // order in which the two pieces of a split field are joined
    typedef enum logic {
        BCF_JOIN_LTR = 1'b0,
        BCF_JOIN_SWAP = 1'b1
    } bcf_join_t;
endpackage : bcf_pkg

// file: tb/bcf_extract_properties.sv
// concurrent checks on the extractor's decoded outputs
`timescale 1ns/1ps
module bcf_extract_checker
    import bcf_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // inputs seen by the extractor
    input wire logic in_valid,
    input wire logic long_branch_form,
    input wire logic [31:0] instr_word,
    input wire logic [31:0] current_instr_address,
    // decoded outputs
    input wire logic out_valid,
    input wire logic absolute_address_flag,
    input wire logic timebase_low_word,
    input wire logic timebase_high_word,
    input wire logic [5:0] primary_opcode,
    input wire logic [9:0] spr_selector,
    input wire logic [9:0] timebase_selector,
    input wire logic [31:0] branch_displacement,
    input wire logic [31:0] long_branch_offset,
    input wire logic [31:0] branch_target,
    input wire logic [4:0] branch_condition_selector,
    input wire logic [4:0] branch_options_field,
    input wire logic [4:0] cond_src_bit_a,
    input wire logic [4:0] cond_dest_bit
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // outputs lag one edge, so the edge that ends reset is not judged
    sequence s_live;
        $past(rst_n);
    endsequence
    property p_valid_flag; s_live |-> out_valid == $past(in_valid) && absolute_address_flag == $past(instr_word[1]);
    endproperty
    a_valid_flag: assert property (p_valid_flag) else $error("valid or flag lag wrong");
    property p_opcode; s_live |-> primary_opcode == $past(instr_word[31:26]); endproperty
    a_opcode: assert property (p_opcode) else $error("opcode mismatch");
    property p_spr; s_live |-> spr_selector == $past(instr_word[20:11]); endproperty
    a_spr: assert property (p_spr) else $error("selector mismatch");
    property p_timebase; s_live |-> timebase_selector == $past(instr_word[20:11])
        && timebase_low_word == ($past(instr_word[20:11]) == BCF_TB_LOW_CODE)
        && timebase_high_word == ($past(instr_word[20:11]) == BCF_TB_HIGH_CODE); endproperty
    a_timebase: assert property (p_timebase) else $error("time base select wrong");
    property p_disp; s_live |-> branch_displacement == {{16{$past(instr_word[15])}}, $past(instr_word[15:2]), 2'b00};
    endproperty
    a_disp: assert property (p_disp) else $error("displacement wrong");
    property p_rel; s_live ##0 $past(!instr_word[1]) |-> branch_target == ($past(current_instr_address)
        & BCF_ALIGN_MASK) + ($past(long_branch_form) ? long_branch_offset : branch_displacement); endproperty
    a_rel: assert property (p_rel) else $error("relative target wrong");
    property p_abs; s_live ##0 $past(instr_word[1]) |->
        branch_target == ($past(long_branch_form) ? long_branch_offset : branch_displacement); endproperty
    a_abs: assert property (p_abs) else $error("absolute target wrong");
    property p_branch_ctl; s_live |-> branch_condition_selector == $past(instr_word[20:16])
        && branch_options_field == $past(instr_word[25:21]); endproperty
    a_branch_ctl: assert property (p_branch_ctl) else $error("branch control fields wrong");
    property p_cond_bits; s_live |-> cond_src_bit_a == $past(instr_word[20:16])
        && cond_dest_bit == $past(instr_word[25:21]); endproperty
    a_cond_bits: assert property (p_cond_bits) else $error("condition bit fields wrong");
endmodule : bcf_extract_checker

// file: tb/bcf_fetch_model.sv
// fetch stand-in presenting one word per cycle at the falling edge
`timescale 1ns/1ps
module bcf_fetch_model (
    // clock
    input wire logic core_clk,
    // instruction toward the extractor
    output logic in_valid,
    output logic [31:0] instr_word,
    output logic [31:0] current_instr_address,
    // per-instruction hints
    output logic long_branch_form,
    output logic [31:0] reserved_mask,
    output logic [31:0] fixed_mask,
    output logic [31:0] fixed_value,
    output bcf_pkg::bcf_join_t split_order
);
    import bcf_pkg::*;
    initial begin
        {in_valid, long_branch_form, instr_word, current_instr_address} = '0;
        {reserved_mask, fixed_mask, fixed_value} = '0;
        split_order = BCF_JOIN_LTR;
    end
    task issue(input logic [31:0] w, a, input logic lf, input bcf_join_t so, input logic [31:0] rm, fm, fv);
        @(negedge core_clk);
        {in_valid, instr_word, current_instr_address, long_branch_form} = {1'b1, w, a, lf};
        {reserved_mask, fixed_mask, fixed_value} = {rm, fm, fv};
        split_order = so;
    endtask : issue
    // stale word is inverted once per idle call so it never looks current
    task idle;
        @(negedge core_clk);
        in_valid = 1'b0;
        instr_word = ~instr_word;
    endtask : idle
endmodule : bcf_fetch_model

// file: tb/branch_cr_field_extractor_tb.sv
// self-checking bench for the branch and condition-register field extractor
`timescale 1ns/1ps
module branch_cr_field_extractor_tb;
    import bcf_pkg::*;
    logic core_clk, rst_n, in_valid, long_branch_form, out_valid, invalid_form;
    logic timebase_low_word, timebase_high_word, absolute_address_flag;
    logic [31:0] instr_word, current_instr_address, reserved_mask, fixed_mask, fixed_value;
    logic [31:0] branch_displacement, long_branch_offset, branch_target;
    logic [9:0] spr_selector, timebase_selector;
    logic [5:0] primary_opcode, rotate_count, mask_begin, mask_end;
    logic [4:0] branch_condition_selector, branch_options_field, cond_src_bit_a, cond_src_bit_b, cond_dest_bit;
    logic [2:0] cond_dest_field, cond_src_field;
    bcf_join_t split_order;
    int fails = 0;
    int num_checks = 0;
    bcf_extract u_bcf_extract (
        .core_clk(core_clk), .rst_n(rst_n), .in_valid(in_valid), .instr_word(instr_word),
        .current_instr_address(current_instr_address), .long_branch_form(long_branch_form),
        .split_order(split_order), .reserved_mask(reserved_mask), .fixed_mask(fixed_mask),
        .fixed_value(fixed_value), .out_valid(out_valid), .primary_opcode(primary_opcode),
        .spr_selector(spr_selector), .timebase_selector(timebase_selector),
        .timebase_low_word(timebase_low_word), .timebase_high_word(timebase_high_word),
        .absolute_address_flag(absolute_address_flag), .branch_displacement(branch_displacement),
        .long_branch_offset(long_branch_offset), .branch_target(branch_target),
        .branch_condition_selector(branch_condition_selector), .branch_options_field(branch_options_field),
        .cond_src_bit_a(cond_src_bit_a), .cond_src_bit_b(cond_src_bit_b), .cond_dest_bit(cond_dest_bit),
        .cond_dest_field(cond_dest_field), .cond_src_field(cond_src_field), .rotate_count(rotate_count),
        .mask_begin(mask_begin), .mask_end(mask_end), .invalid_form(invalid_form)
    );
    bcf_fetch_model u_bcf_fetch_model (
        .core_clk(core_clk), .in_valid(in_valid), .long_branch_form(long_branch_form),
        .instr_word(instr_word), .current_instr_address(current_instr_address), .reserved_mask(reserved_mask),
        .fixed_mask(fixed_mask), .fixed_value(fixed_value), .split_order(split_order)
    );
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop
    // fields are registered: look just after the next rising edge
    task go(input logic [31:0] w, a = 0, input logic lf = 0, input bcf_join_t so = BCF_JOIN_LTR,
            input logic [31:0] rm = 0, fm = 0, fv = 0);
        u_bcf_fetch_model.issue(w, a, lf, so, rm, fm, fv);
        @(posedge core_clk);
        #1;
    endtask : go
    task t_fields;
        go({6'h13, 5'h15, 5'h0a, 5'h1c, 11'h2a5});
        check({out_valid, primary_opcode}, {1'b1, 6'h13});
        check(spr_selector, {5'h0a, 5'h1c});
        check({branch_condition_selector, branch_options_field}, {5'h0a, 5'h15});
        check({cond_src_bit_a, cond_src_bit_b}, {5'h0a, 5'h1c});
        check({cond_dest_bit, cond_dest_field, cond_src_field}, {5'h15, 3'h5, 3'h2});
        go({11'h0, BCF_TB_LOW_CODE, 11'h0});
        check({timebase_selector, timebase_low_word, timebase_high_word}, {BCF_TB_LOW_CODE, 2'b10});
        go({11'h0, BCF_TB_HIGH_CODE, 11'h0});
        check({timebase_low_word, timebase_high_word}, 2'b01);
        u_bcf_fetch_model.idle;
        @(posedge core_clk);
        #1;
        check(out_valid, 1'b0);
        $display("t_fields done");
    endtask : t_fields
    task t_branch;
        go({16'h0, 14'h2000, 2'b00}, 32'h0001_0007);
        check(branch_displacement, 32'hffff_8000);
        check(branch_target, 32'h0000_8004);
        go({16'h0, 14'h1fff, 2'b10}, 32'h0001_0007);
        check({absolute_address_flag, branch_target}, {1'b1, 32'h0000_7ffc});
        go({6'h12, 24'h80_0001, 2'b00}, 32'h0200_0003, 1'b1);
        check(long_branch_offset, 32'hfe00_0004);
        check(branch_target, 32'h0000_0004);
        $display("t_branch done");
    endtask : t_branch
    task t_split;
        logic [17:0] exp [2];
        exp[0] = {6'h27, 6'h0a, 6'h12};
        exp[1] = {6'h33, 6'h05, 6'h09};
        for (int i = 0; i < 2; i++) begin
            go({16'h0, 5'h13, 5'h05, 5'h09, 1'b0}, 0, 0, bcf_join_t'(i));
            check({rotate_count, mask_begin, mask_end}, exp[i]);
        end
        $display("t_split done");
    endtask : t_split
    task t_invalid;
        go(32'h1300_0001, 0, 0, BCF_JOIN_LTR, 32'h1);
        check(invalid_form, 1'b1);
        go(32'h1300_0000, 0, 0, BCF_JOIN_LTR, 32'h1, 32'hff00_0000, 32'h1200_0000);
        check(invalid_form, 1'b1);
        go(32'h1200_0000, 0, 0, BCF_JOIN_LTR, 32'h1, 32'hff00_0000, 32'h1200_0000);
        check(invalid_form, 1'b0);
        $display("t_invalid done");
    endtask : t_invalid
    // mid-run reset must clear the pipeline at once
    task t_reset;
        @(negedge core_clk);
        rst_n = 1'b0;
        #1;
        check({out_valid, primary_opcode}, 7'h00);
        @(negedge core_clk);
        rst_n = 1'b1;
        $display("t_reset done");
    endtask : t_reset
    initial begin
        rst_n = 1'b0;
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        t_fields;
        t_branch;
        t_split;
        t_invalid;
        t_reset;
        t_fields;
        report_and_stop;
    end
    initial begin
        repeat (2000) @(posedge core_clk);
        fails++;
        report_and_stop;
    end
endmodule : branch_cr_field_extractor_tb
bind bcf_extract bcf_extract_checker u_bcf_extract_checker (
    .core_clk(core_clk), .rst_n(rst_n), .in_valid(in_valid), .long_branch_form(long_branch_form),
    .instr_word(instr_word), .current_instr_address(current_instr_address), .out_valid(out_valid),
    .absolute_address_flag(absolute_address_flag), .timebase_low_word(timebase_low_word),
    .timebase_high_word(timebase_high_word), .primary_opcode(primary_opcode), .spr_selector(spr_selector),
    .timebase_selector(timebase_selector), .branch_displacement(branch_displacement),
    .long_branch_offset(long_branch_offset), .branch_target(branch_target),
    .branch_condition_selector(branch_condition_selector), .branch_options_field(branch_options_field),
    .cond_src_bit_a(cond_src_bit_a), .cond_dest_bit(cond_dest_bit));
